/* src/ladr_pkg.sv */
// Constants and types for the legacy address decode router.
// Assumes a single clock and a requester that presents one access at a time.
package ladr_pkg;

	localparam int ADDR_W = 36;
	localparam int DATA_W = 32;
	localparam int SEG_N = 13;

	localparam logic [ADDR_W-1:0] DOS_TOP = 36'h0_000A_0000;
	localparam logic [ADDR_W-1:0] VID_TOP = 36'h0_000C_0000;
	localparam logic [ADDR_W-1:0] MDA_BASE = 36'h0_000B_0000;
	localparam logic [ADDR_W-1:0] MDA_TOP = 36'h0_000B_8000;
	localparam logic [ADDR_W-1:0] BIOS_BASE = 36'h0_000F_0000;
	localparam logic [ADDR_W-1:0] LOW_TOP = 36'h0_0010_0000;
	localparam logic [ADDR_W-1:0] MEM_LIMIT = 36'h1_0000_0000;
	localparam logic [ADDR_W-1:0] IO_LIMIT = 36'h0_0001_0003;

	localparam int SEG_LSB = 14;
	localparam logic [3:0] BIOS_SEG = 4'hC;
	localparam logic [SEG_N-1:0] ATTR_RST = 13'h0000;

	localparam logic [9:0] VIO_A_LO = 10'h3B0;
	localparam logic [9:0] VIO_A_HI = 10'h3BB;
	localparam logic [9:0] VIO_B_LO = 10'h3C0;
	localparam logic [9:0] VIO_B_HI = 10'h3DF;
	localparam logic [15:0] MIO_0 = 16'h03B4;
	localparam logic [15:0] MIO_1 = 16'h03B5;
	localparam logic [15:0] MIO_2 = 16'h03B8;
	localparam logic [15:0] MIO_3 = 16'h03B9;
	localparam logic [15:0] MIO_4 = 16'h03BA;
	localparam logic [15:0] MIO_5 = 16'h03BF;

	typedef enum logic [1:0] {
		SRC_PROC,
		SRC_HUB_A,
		SRC_HUB_B,
		SRC_GFX
	} ladr_src_t;

	typedef enum logic [2:0] {
		PORT_DRAM,
		PORT_HUB_A,
		PORT_HUB_B,
		PORT_GFX,
		PORT_LOCAL
	} ladr_port_t;

endpackage

/* src/ladr_router.sv */
// Legacy address decode router: routes each access below 1 MB (and I/O)
// to DRAM, hub ports or graphics port, or terminates it locally.
// Assumes requests come from logic on clk_i; one request per cycle.
`timescale 1ns/1ps
`default_nettype none
module ladr_router (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Segment attribute load and readback
	input wire logic attr_wr_i,
	input wire logic [ladr_pkg::SEG_N-1:0] attr_re_i,
	input wire logic [ladr_pkg::SEG_N-1:0] attr_we_i,
	output logic [ladr_pkg::SEG_N-1:0] attr_re_o,
	output logic [ladr_pkg::SEG_N-1:0] attr_we_o,
	// Routing controls
	input wire logic gfx_legacy_video_route_enable_i,
	input wire logic hubb_legacy_video_route_enable_i,
	input wire logic mono_adapter_present_i,
	input wire logic compatible_mgmt_ram_en_i,
	input wire logic [ladr_pkg::ADDR_W-1:0] mem_top_i,
	// Request
	input wire logic req_valid_i,
	input wire ladr_pkg::ladr_src_t req_src_i,
	input wire logic req_io_i,
	input wire logic req_write_i,
	input wire logic req_smm_i,
	input wire logic [ladr_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [ladr_pkg::DATA_W-1:0] req_wdata_i,
	// Forwarded access
	output logic fwd_valid_o,
	output ladr_pkg::ladr_port_t fwd_port_o,
	output logic [ladr_pkg::ADDR_W-1:0] fwd_addr_o,
	output logic fwd_write_o,
	output logic [ladr_pkg::DATA_W-1:0] fwd_wdata_o,
	// Local completion
	output logic loc_done_o,
	output logic loc_write_o,
	output logic [ladr_pkg::DATA_W-1:0] loc_rdata_o
);
	import ladr_pkg::*;

	// ****************************************
	// Segment attributes
	// ****************************************
	logic [SEG_N-1:0] re_ff, we_ff, nxt_re, nxt_we;

	always_comb begin
		nxt_re = re_ff;
		nxt_we = we_ff;
		if (attr_wr_i) begin
			nxt_re = attr_re_i;
			nxt_we = attr_we_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			re_ff <= ATTR_RST;
			we_ff <= ATTR_RST;
		end else begin
			re_ff <= nxt_re;
			we_ff <= nxt_we;
		end
	end

	assign attr_re_o = re_ff;
	assign attr_we_o = we_ff;

	// ****************************************
	// Decode
	// ****************************************
	ladr_port_t nxt_port, port_ff;
	logic nxt_fwd, nxt_loc, fwd_ff, loc_ff, write_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;

	always_comb begin
		logic [3:0] seg;
		logic seg_on, vid, mda_mem, mda_io, vio;
		ladr_port_t vport;
		seg = BIOS_SEG;
		seg_on = 1'b0;
		vid = 1'b0;
		mda_mem = 1'b0;
		mda_io = 1'b0;
		vio = 1'b0;
		vport = PORT_HUB_A;
		nxt_port = PORT_LOCAL;
		// Segment index: C0000-EFFFF use bits 17:14, F0000 up is one
		if ((req_addr_i >= VID_TOP) && (req_addr_i < BIOS_BASE)) begin
			seg = req_addr_i[SEG_LSB+3:SEG_LSB];
		end
		seg_on = req_write_i ? we_ff[seg] : re_ff[seg];
		vid = (req_addr_i >= DOS_TOP) && (req_addr_i < VID_TOP);
		mda_mem = mono_adapter_present_i && (req_addr_i >= MDA_BASE) &&
			(req_addr_i < MDA_TOP);
		mda_io = mono_adapter_present_i && ((req_addr_i[15:0] == MIO_0) ||
			(req_addr_i[15:0] == MIO_1) || (req_addr_i[15:0] == MIO_2) ||
			(req_addr_i[15:0] == MIO_3) || (req_addr_i[15:0] == MIO_4) ||
			(req_addr_i[15:0] == MIO_5)) && (req_addr_i < LOW_TOP);
		vio = hubb_legacy_video_route_enable_i &&
			(((req_addr_i[9:0] >= VIO_A_LO) && (req_addr_i[9:0] <= VIO_A_HI)) ||
			((req_addr_i[9:0] >= VIO_B_LO) && (req_addr_i[9:0] <= VIO_B_HI)));
		// Video target: graphics enable wins over secondary hub
		if (gfx_legacy_video_route_enable_i) begin
			vport = PORT_GFX;
		end else if (hubb_legacy_video_route_enable_i) begin
			vport = PORT_HUB_B;
		end else begin
			vport = PORT_HUB_A;
		end
		if (req_io_i) begin
			if (req_addr_i >= IO_LIMIT) begin
				nxt_port = PORT_LOCAL;
			end else if (mda_io) begin
				nxt_port = PORT_HUB_A;
			end else if (vio) begin
				nxt_port = PORT_HUB_B;
			end else begin
				nxt_port = PORT_HUB_A;
			end
		end else if (req_addr_i >= MEM_LIMIT) begin
			nxt_port = PORT_LOCAL;
		end else if (req_addr_i < DOS_TOP) begin
			nxt_port = PORT_DRAM;
		end else if (vid && compatible_mgmt_ram_en_i &&
			(req_src_i == SRC_PROC) && req_smm_i) begin
			nxt_port = PORT_DRAM;
		end else if (vid) begin
			// Non-mgmt processor and all agent cycles fall here
			if (mda_mem) begin
				nxt_port = PORT_HUB_A;
			end else begin
				nxt_port = vport;
			end
			// Graphics to hub and hub to graphics are not carried
			if (((req_src_i == SRC_GFX) && (nxt_port != PORT_GFX)) ||
				((req_src_i != SRC_GFX) && (req_src_i != SRC_PROC) &&
				(nxt_port == PORT_GFX))) begin
				nxt_port = PORT_LOCAL;
			end
		end else if (req_addr_i < LOW_TOP) begin
			nxt_port = seg_on ? PORT_DRAM : PORT_HUB_A;
		end else if (req_addr_i < mem_top_i) begin
			nxt_port = PORT_DRAM;
		end else begin
			nxt_port = PORT_HUB_A;
		end
		nxt_fwd = req_valid_i && (nxt_port != PORT_LOCAL);
		nxt_loc = req_valid_i && (nxt_port == PORT_LOCAL);
		nxt_wdata = nxt_fwd ? req_wdata_i : '0;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_ff <= PORT_LOCAL;
			fwd_ff <= 1'b0;
			loc_ff <= 1'b0;
			write_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
		end else begin
			port_ff <= nxt_port;
			fwd_ff <= nxt_fwd;
			loc_ff <= nxt_loc;
			write_ff <= req_write_i;
			addr_ff <= req_addr_i;
			wdata_ff <= nxt_wdata;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign fwd_valid_o = fwd_ff;
	assign fwd_port_o = port_ff;
	assign fwd_addr_o = addr_ff;
	assign fwd_write_o = write_ff;
	assign fwd_wdata_o = wdata_ff;
	assign loc_done_o = loc_ff;
	assign loc_write_o = write_ff;
	assign loc_rdata_o = '0;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic req_mem, req_vid, vid_plain;
	assign req_mem = req_valid_i && !req_io_i;
	assign req_vid = req_mem && (req_addr_i >= DOS_TOP) &&
		(req_addr_i < VID_TOP) && !mono_adapter_present_i;
	assign vid_plain = req_vid && !compatible_mgmt_ram_en_i &&
		(req_src_i == SRC_PROC);

	chk_high_local: assert property (req_mem &&
		req_addr_i >= MEM_LIMIT |=> loc_done_o && !fwd_valid_o)
		else $error("high access not terminated locally");
	chk_write_drop: assert property (req_valid_i && req_io_i &&
		req_write_i && req_addr_i >= IO_LIMIT |=>
		loc_done_o && loc_write_o && !fwd_valid_o && fwd_wdata_o == '0)
		else $error("invalid write not discarded");
	chk_read_zero: assert property (req_mem && !req_write_i &&
		req_addr_i >= MEM_LIMIT |=> loc_done_o && loc_rdata_o == '0)
		else $error("invalid read data not zero");
	chk_dos_dram: assert property (req_mem && req_addr_i < DOS_TOP |=>
		fwd_valid_o && fwd_port_o == PORT_DRAM)
		else $error("low area not sent to dram");
	chk_vid_default: assert property (vid_plain &&
		!gfx_legacy_video_route_enable_i &&
		!hubb_legacy_video_route_enable_i |=> fwd_port_o == PORT_HUB_A)
		else $error("video default route wrong");
	chk_vid_gfx: assert property (vid_plain &&
		gfx_legacy_video_route_enable_i |=> fwd_port_o == PORT_GFX)
		else $error("video not routed to graphics");
	chk_vid_hubb: assert property (vid_plain &&
		!gfx_legacy_video_route_enable_i &&
		hubb_legacy_video_route_enable_i |=> fwd_port_o == PORT_HUB_B)
		else $error("video not routed to secondary hub");
	chk_gfx_hub: assert property (req_vid && req_src_i == SRC_GFX &&
		!gfx_legacy_video_route_enable_i |=> loc_done_o && !fwd_valid_o)
		else $error("graphics to hub access carried");
	chk_smm_dram: assert property (req_vid && compatible_mgmt_ram_en_i &&
		req_src_i == SRC_PROC && req_smm_i |=> fwd_port_o == PORT_DRAM)
		else $error("management access missed dram");
	chk_agent_vid: assert property (req_vid && req_src_i == SRC_HUB_A &&
		compatible_mgmt_ram_en_i && !gfx_legacy_video_route_enable_i |=>
		fwd_valid_o && fwd_port_o != PORT_DRAM)
		else $error("agent reached management dram");
	chk_mda_io: assert property (req_valid_i && req_io_i &&
		mono_adapter_present_i && req_addr_i == 36'h0_0000_03B5 |=>
		fwd_port_o == PORT_HUB_A)
		else $error("mono port not sent to primary hub");
	chk_seg_attr: assert property (req_mem && req_addr_i >= VID_TOP &&
		req_addr_i < LOW_TOP && !req_write_i &&
		!re_ff[req_addr_i >= BIOS_BASE ? BIOS_SEG :
		req_addr_i[SEG_LSB+3:SEG_LSB]] |=> fwd_port_o == PORT_HUB_A)
		else $error("disabled segment not passed on");
	chk_vio_hubb: assert property (req_valid_i && req_io_i &&
		req_addr_i < IO_LIMIT && req_addr_i[9:0] == VIO_B_LO &&
		hubb_legacy_video_route_enable_i |=> fwd_port_o == PORT_HUB_B)
		else $error("video port not sent to secondary hub");

	chk_smm_video: assert property (req_vid && compatible_mgmt_ram_en_i &&
		req_src_i == SRC_PROC && !req_smm_i &&
		gfx_legacy_video_route_enable_i |=> fwd_port_o == PORT_GFX)
		else $error("plain processor video access misrouted");

	chk_mda_mem: assert property (req_mem && mono_adapter_present_i &&
		req_addr_i >= MDA_BASE && req_addr_i < MDA_TOP &&
		req_src_i == SRC_PROC && !req_smm_i |=>
		fwd_valid_o && fwd_port_o == PORT_HUB_A)
		else $error("mono memory not sent to primary hub");

	chk_mda_smm: assert property (req_mem && mono_adapter_present_i &&
		req_addr_i >= MDA_BASE && req_addr_i < MDA_TOP &&
		compatible_mgmt_ram_en_i && req_src_i == SRC_PROC && req_smm_i |=>
		fwd_port_o == PORT_DRAM)
		else $error("management access lost to mono range");

	chk_gfx_src: assert property (req_vid && req_src_i != SRC_PROC &&
		req_src_i != SRC_GFX && gfx_legacy_video_route_enable_i |=>
		loc_done_o && !fwd_valid_o)
		else $error("hub to graphics access carried");

	chk_seg_write: assert property (req_mem && req_write_i &&
		req_addr_i >= VID_TOP && req_addr_i < LOW_TOP &&
		we_ff[req_addr_i >= BIOS_BASE ? BIOS_SEG :
		req_addr_i[SEG_LSB+3:SEG_LSB]] |=>
		fwd_valid_o && fwd_port_o == PORT_DRAM)
		else $error("enabled segment write missed dram");

	chk_mem_wdrop: assert property (req_mem && req_write_i &&
		req_addr_i >= MEM_LIMIT |=> !fwd_valid_o && fwd_wdata_o == '0)
		else $error("invalid memory write not discarded");

	chk_io_valid: assert property (req_valid_i && req_io_i &&
		req_addr_i < IO_LIMIT |=> fwd_valid_o && !loc_done_o)
		else $error("valid io access not forwarded");

	chk_attr_load: assert property (attr_wr_i |=>
		attr_re_o == $past(attr_re_i) && attr_we_o == $past(attr_we_i))
		else $error("segment attributes not loaded");

	chk_one_answer: assert property (req_valid_i |=>
		fwd_valid_o != loc_done_o)
		else $error("request not answered exactly once");

	chk_idle_quiet: assert property (!req_valid_i |=>
		!fwd_valid_o && !loc_done_o)
		else $error("answer without request");

	cov_vid_gfx: cover property (fwd_valid_o && fwd_port_o == PORT_GFX);
	cov_smm_dram: cover property (req_vid && req_smm_i ##1
		fwd_port_o == PORT_DRAM);
	cov_loc_read: cover property (loc_done_o && !loc_write_o);
	cov_seg_dram: cover property (req_mem && req_addr_i >= BIOS_BASE &&
		req_addr_i < LOW_TOP ##1 fwd_port_o == PORT_DRAM);
	cov_mda_hub: cover property (req_mem && mono_adapter_present_i &&
		req_addr_i >= MDA_BASE && req_addr_i < MDA_TOP ##1
		fwd_port_o == PORT_HUB_A);

endmodule
`default_nettype wire

/* tb/ladr_far_model.sv */
// Far-side agents of the router: count forwarded accesses, keep last write.
// Assumes the router's forwarded outputs, sampled on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ladr_far_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Forwarded access
	input wire logic fwd_valid_i,
	input wire logic fwd_write_i,
	input wire logic [ladr_pkg::DATA_W-1:0] fwd_wdata_i,
	// Observation
	output logic [15:0] cnt_o,
	output logic [ladr_pkg::DATA_W-1:0] wdata_o
);
	import ladr_pkg::*;
	// ************************************
	// Agent bookkeeping
	// ************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_o <= 16'h0000;
			wdata_o <= '0;
		end else if (fwd_valid_i) begin
			cnt_o <= cnt_o + 16'h0001;
			if (fwd_write_i)
				wdata_o <= fwd_wdata_i;
		end
	end
endmodule
`default_nettype wire

/* tb/ladr_router_tb.sv */
// Self-checking testbench for the legacy address decode router.
// Assumes ladr_pkg and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ladr_router_tb;
	import ladr_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic aw, gfx, hubb, mono, smr, rv, io, wr, smm, fv, fw, ld, lw;
	logic [SEG_N-1:0] are, awe, are_o, awe_o;
	logic [ADDR_W-1:0] addr, fa, sa, sz;
	logic [DATA_W-1:0] wd, fwd_wd, rd, m_wd, exp_wd;
	logic [15:0] m_cnt;
	ladr_src_t src;
	ladr_port_t fp;
	int n_fail = 0;
	int total_checks = 0;
	int exp_cnt = 0;
	ladr_port_t ev [3][4] = '{'{PORT_HUB_A, PORT_HUB_A, PORT_HUB_A, PORT_LOCAL},
		'{PORT_GFX, PORT_LOCAL, PORT_LOCAL, PORT_GFX},
		'{PORT_HUB_B, PORT_HUB_B, PORT_HUB_B, PORT_LOCAL}};
	logic [15:0] mio [6] = '{MIO_0, MIO_1, MIO_2, MIO_3, MIO_4, MIO_5};
	logic [15:0] vio [5] = '{16'h03B0, 16'h03BB, 16'h03C0, 16'h03DF, 16'hFFC0};

	always #12.5 clk_i = ~clk_i;

	ladr_router i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .attr_wr_i(aw),
		.attr_re_i(are), .attr_we_i(awe), .attr_re_o(are_o), .attr_we_o(awe_o),
		.gfx_legacy_video_route_enable_i(gfx),
		.hubb_legacy_video_route_enable_i(hubb),
		.mono_adapter_present_i(mono), .compatible_mgmt_ram_en_i(smr),
		.mem_top_i(36'h0_4000_0000), .req_valid_i(rv), .req_src_i(src),
		.req_io_i(io), .req_write_i(wr), .req_smm_i(smm), .req_addr_i(addr),
		.req_wdata_i(wd), .fwd_valid_o(fv), .fwd_port_o(fp), .fwd_addr_o(fa),
		.fwd_write_o(fw), .fwd_wdata_o(fwd_wd), .loc_done_o(ld),
		.loc_write_o(lw), .loc_rdata_o(rd));

	ladr_far_model i_far (.clk_i(clk_i), .nrst_i(nrst_i), .fwd_valid_i(fv),
		.fwd_write_i(fw), .fwd_wdata_i(fwd_wd), .cnt_o(m_cnt), .wdata_o(m_wd));

	task automatic chk(input string nm, input logic [35:0] e,
		input logic [35:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic acc(input ladr_src_t s, input logic i, input logic w,
		input logic sm, input logic [35:0] a, input ladr_port_t p);
		@(posedge clk_i);
		rv <= 1'b1;
		src <= s;
		io <= i;
		wr <= w;
		smm <= sm;
		addr <= a;
		wd <= ~a[31:0];
		@(posedge clk_i);
		rv <= 1'b0;
		#1;
		chk("forward valid", p != PORT_LOCAL, fv);
		chk("local done", p == PORT_LOCAL, ld);
		if (p != PORT_LOCAL) begin
			chk("port", p, fp);
			chk("address", a, fa);
			chk("direction", w, fw);
			chk("forward data", {4'h0, ~a[31:0]}, fwd_wd);
			exp_cnt++;
			if (w)
				exp_wd = ~a[31:0];
		end else begin
			chk("read data", '0, rd);
			chk("local write", w, lw);
			chk("forward data", '0, fwd_wd);
		end
		@(posedge clk_i);
		#1;
		chk("far count", exp_cnt, m_cnt);
		chk("far data", exp_wd, m_wd);
	endtask

	task automatic attr(input logic [SEG_N-1:0] r, input logic [SEG_N-1:0] w);
		@(posedge clk_i);
		aw <= 1'b1;
		are <= r;
		awe <= w;
		@(posedge clk_i);
		aw <= 1'b0;
		#1;
		chk("read enables", r, are_o);
		chk("write enables", w, awe_o);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#(25 * 20000);
		n_fail++;
		stop_test();
	end

	// ************************************
	// Tests
	// ************************************
	initial begin
		{aw, gfx, hubb, mono, smr, rv, io, wr, smm} = '0;
		{are, awe, addr, wd} = '0;
		exp_wd = '0;
		src = SRC_PROC;
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		chk("reset enables", '0, {are_o, awe_o});
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_000F_8000, PORT_HUB_A);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0, PORT_DRAM);
		$display("test reset done");
		for (int k = 0; k < 3; k++) begin
			gfx <= (k == 1);
			hubb <= (k == 2);
			acc(SRC_HUB_B, 1'b0, 1'b1, 1'b1, 36'h0_0009_FFFF, PORT_DRAM);
			for (int s = 0; s < 4; s++)
				acc(ladr_src_t'(s), 1'b0, 1'b0, 1'b0,
					36'h0_000A_8000, ev[k][s]);
		end
		$display("test video routing done");
		hubb <= 1'b0;
		gfx <= 1'b0;
		smr <= 1'b1;
		acc(SRC_HUB_A, 1'b0, 1'b0, 1'b1, 36'h0_000A_0000, PORT_HUB_A);
		gfx <= 1'b1;
		acc(SRC_PROC, 1'b0, 1'b0, 1'b1, 36'h0_000A_0000, PORT_DRAM);
		acc(SRC_PROC, 1'b0, 1'b1, 1'b1, 36'h0_000B_FFFF, PORT_DRAM);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_000A_0000, PORT_GFX);
		acc(SRC_GFX, 1'b0, 1'b0, 1'b1, 36'h0_000A_0000, PORT_GFX);
		mono <= 1'b1;
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_000B_0000, PORT_HUB_A);
		acc(SRC_PROC, 1'b0, 1'b1, 1'b0, 36'h0_000B_7FFF, PORT_HUB_A);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_000B_8000, PORT_GFX);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b1, 36'h0_000B_0000, PORT_DRAM);
		$display("test management and mono done");
		hubb <= 1'b1;
		for (int j = 0; j < 6; j++)
			acc(SRC_PROC, 1'b1, 1'b1, 1'b0, {20'h0, mio[j]}, PORT_HUB_A);
		for (int j = 0; j < 5; j++)
			acc(SRC_PROC, 1'b1, 1'b0, 1'b0, {20'h0, vio[j]}, PORT_HUB_B);
		acc(SRC_PROC, 1'b1, 1'b0, 1'b0, 36'h3BC, PORT_HUB_A);
		mono <= 1'b0;
		acc(SRC_PROC, 1'b1, 1'b0, 1'b0, 36'h3B4, PORT_HUB_B);
		hubb <= 1'b0;
		acc(SRC_PROC, 1'b1, 1'b0, 1'b0, 36'h3C0, PORT_HUB_A);
		acc(SRC_PROC, 1'b1, 1'b0, 1'b0, 36'h1_0002, PORT_HUB_A);
		acc(SRC_PROC, 1'b1, 1'b1, 1'b0, 36'h1_0003, PORT_LOCAL);
		$display("test io routing done");
		for (int i = 0; i < SEG_N; i++) begin
			sa = 36'h0_000C_0000 + 36'(i) * 36'h4000;
			sz = (i == 12) ? 36'hFFFF : 36'h3FFF;
			attr(13'h0001 << i, 13'h0000);
			acc(SRC_PROC, 1'b0, 1'b0, 1'b0, sa, PORT_DRAM);
			acc(SRC_PROC, 1'b0, 1'b1, 1'b0, sa + sz, PORT_HUB_A);
			attr(13'h0000, 13'h0001 << i);
			acc(SRC_PROC, 1'b0, 1'b1, 1'b0, sa + sz, PORT_DRAM);
			acc(SRC_PROC, 1'b0, 1'b0, 1'b0, sa, PORT_HUB_A);
			acc(SRC_PROC, 1'b0, 1'b1, 1'b0, sa + sz + 36'h1,
				(i == 12) ? PORT_DRAM : PORT_HUB_A);
		end
		$display("test segments done");
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h1_0000_0000, PORT_LOCAL);
		acc(SRC_HUB_A, 1'b0, 1'b1, 1'b0, 36'hF_FFFF_FFFC, PORT_LOCAL);
		acc(SRC_PROC, 1'b0, 1'b1, 1'b0, 36'h0_3FFF_FFFF, PORT_DRAM);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_4000_0000, PORT_HUB_A);
		acc(SRC_PROC, 1'b0, 1'b0, 1'b0, 36'h0_FFFF_FFFF, PORT_HUB_A);
		$display("test invalid space done");
		stop_test();
	end
endmodule
`default_nettype wire
